// ---- pss_pkg.sv ----
// Package: timing constants, register map and states of the power state sequencer
package pss_pkg;

    // Clocks
    localparam int CLK_PERIOD_NS     = 4;
    localparam int SLOW_PERIOD_NS    = 31250;
    localparam int SLOW_TICK_CYCLES  = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SLOW_TICKS_PER_MS = 1000000 / SLOW_PERIOD_NS;
    localparam int CW                = 18;

    // Switch-on slots, in slow periods
    localparam int ON_FIRST_TICKS  = 66;
    localparam int ON_SLOT_TICKS   = 64;
    localparam int ON_CLK_SLOTS    = 9;
    localparam int ON_IO_AT        = ON_FIRST_TICKS;
    localparam int ON_CORE2_AT     = ON_IO_AT + ON_SLOT_TICKS;
    localparam int ON_CORE1_AT     = ON_CORE2_AT + ON_SLOT_TICKS;
    localparam int ON_LINEAR_REG_4_AT      = ON_CORE1_AT + ON_SLOT_TICKS;
    localparam int ON_LDO38_AT     = ON_LINEAR_REG_4_AT + ON_SLOT_TICKS;
    localparam int ON_LINEAR_REG_6_AT      = ON_LDO38_AT + ON_SLOT_TICKS;
    localparam int ON_CLK_AT       = ON_LINEAR_REG_6_AT + ON_CLK_SLOTS * ON_SLOT_TICKS;
    localparam int ON_RST_AT       = ON_CLK_AT + ON_SLOT_TICKS;

    // Switch-off, in slow periods from hold removal
    localparam int OFF_RST_AT      = 2;
    localparam int OFF_CLK_TICKS   = 3;
    localparam int OFF_SUPPLY_AT   = 5;

    // Input debounce, in slow periods
    localparam int PB_FALL_MS      = 100;
    localparam int PB_FALL_TICKS   = PB_FALL_MS * SLOW_TICKS_PER_MS;
    localparam int PB_RISE_TICKS   = 3;
    localparam int HOLD_RISE_TICKS = 2;
    localparam int HOLD_FALL_TICKS = 0;
    localparam int SLP_SYNC_TICKS  = 2;

    // Power-on pulse and long press
    localparam int PULSE_MS        = 1000;
    localparam int PULSE_TICKS     = PULSE_MS * SLOW_TICKS_PER_MS;
    localparam int LONG_MS         = 4000;
    localparam int LONG_TICKS      = LONG_MS * SLOW_TICKS_PER_MS;
    localparam int LP_OFF_MS       = 1000;
    localparam int LP_OFF_TICKS    = LP_OFF_MS * SLOW_TICKS_PER_MS;

    // Sleep, counted from the resynchronised sleep edge
    localparam int SLP_CLK_TICKS   = 3;
    localparam int WAKE_HP_AT      = 8 - SLP_SYNC_TICKS;
    localparam int WAKE_CLK_AT     = WAKE_HP_AT + 3;
    localparam int WAKE_STEP1_AT   = WAKE_HP_AT + 1;
    localparam int WAKE_BUCK_TICKS = 2;
    localparam int STEP_US_01      = 200;
    localparam int STEP_US_10      = 500;
    localparam int STEP_US_11      = 2000;
    localparam int STEP_TICKS_01   = STEP_US_01 * 1000 / SLOW_PERIOD_NS;
    localparam int STEP_TICKS_10   = STEP_US_10 * 1000 / SLOW_PERIOD_NS;
    localparam int STEP_TICKS_11   = STEP_US_11 * 1000 / SLOW_PERIOD_NS;

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EVENT  = 8'h08;
    localparam int CTRL_DEV_KEEP   = 0;
    localparam int CTRL_AUTO_KEEP  = 1;
    localparam int CTRL_SLOT_LO    = 2;
    localparam int CTRL_MASK_LO    = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_OFF, ST_START, ST_ACTIVE, ST_STOP, ST_SLEEP_IN, ST_SLEEP, ST_WAKE
    } pss_state_t;

endpackage

// ---- pss_slow_tick.sv ----
// Internal slow clock: one-cycle tick per period plus a half-period phase
`timescale 1ns/1ps
module pss_slow_tick
    import pss_pkg::*;
#(
    parameter int DIV = SLOW_TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    output logic      tick,
    output logic      phase
);
    logic [CW-1:0] div;

    if (DIV < 2 || DIV >= (1 << CW)) begin : g_chk
        $error("pss_slow_tick: DIV out of range");
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div   <= '0;
            tick  <= 1'b0;
            phase <= 1'b0;
        end else begin
            tick <= (div == CW'(DIV - 1));
            div  <= (div == CW'(DIV - 1)) ? '0 : div + 1'b1;
            phase <= (div < CW'(DIV / 2));
        end
    end
endmodule

// ---- pss_debounce.sv ----
// Two-stage synchroniser followed by a level debouncer counted in slow ticks
`timescale 1ns/1ps
module pss_debounce
    import pss_pkg::*;
#(
    parameter int  RISE_TICKS = 2,
    parameter int  FALL_TICKS = 0,
    parameter logic INIT      = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic tick,
    input  wire logic pinIn,
    output logic      level
);
    logic [1:0]    sync;
    logic [CW-1:0] cnt;
    logic [CW-1:0] need;

    if (RISE_TICKS >= (1 << CW) || FALL_TICKS >= (1 << CW)) begin : g_chk
        $error("pss_debounce: debounce count too wide");
    end

    assign need = sync[1] ? CW'(RISE_TICKS) : CW'(FALL_TICKS);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync <= {INIT, INIT};
        end else begin
            sync <= {sync[0], pinIn};
        end
    end

    // Any bounce restarts the stability count
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt   <= '0;
            level <= INIT;
        end else if (sync[1] == level) begin
            cnt <= '0;
        end else if (need == '0) begin
            level <= sync[1];
        end else if (tick) begin
            if (cnt + 1'b1 >= need) begin
                level <= sync[1];
                cnt   <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// ---- pss_sequencer.sv ----
// Power state sequencer: switch-on/off slots, long press, sleep, APB registers
//
// Notes on behaviour
// - first slot 66 periods after hold rise
// - further rails every 64 periods, fixed order
// - clock 9 slots later, resets one slot after
// - resets low 2 periods after hold falls
// - slow clock stops 3 periods after resets
// - all supplies off 5 periods after hold
// - button press valid after 100 ms low
// - button release debounced three periods
// - hold rise debounced two periods
// - debounced press gives 1 s power-on pulse
// - keep-on bits substitute for hold input
// - 4 s press: event, off 1 s later
// - sleep entry: low power, clock stops later
// - sleep exit: high power, clock restarts
// - wake step 1 one period after high power
// - wake step length from slot select
// - wake bucks enabled two periods into step
// - processor reset output driven by sequencer
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int TICK_DIV      = SLOW_TICK_CYCLES,
    parameter int PB_FALL       = PB_FALL_TICKS,
    parameter int PULSE_LEN     = PULSE_TICKS,
    parameter int LONG_LEN      = LONG_TICKS,
    parameter int LP_OFF_LEN    = LP_OFF_TICKS
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        holdRequestIn,
    input  wire logic        powerButtonInN,
    input  wire logic        sleepInN,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             ioBuckEn,
    output logic             core1BuckEn,
    output logic             core2BuckEn,
    output logic             linearReg3En,
    output logic             linearReg4En,
    output logic             linearReg5En,
    output logic             linearReg6En,
    output logic             linearReg8En,
    output logic             referenceEn,
    output logic             lowPowerMode,
    output logic             slowClockOut,
    output logic             processorResetN,
    output logic             secondResetN,
    output logic             longPressEvent
);

    if (LONG_LEN <= PB_FALL || PULSE_LEN >= (1 << CW) || LONG_LEN >= (1 << CW)
        || LP_OFF_LEN >= (1 << CW) || PB_FALL < 1) begin : g_chk
        $error("pss_sequencer: timing parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slow tick and input conditioning

    logic tick;
    logic phase;
    logic holdDeb;
    logic buttonUp;
    logic awake;
    logic holdPrev;
    logic buttonPrev;
    logic awakePrev;

    pss_slow_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick),
        .phase   (phase)
    );

    pss_debounce #(.RISE_TICKS(HOLD_RISE_TICKS), .FALL_TICKS(HOLD_FALL_TICKS),
                   .INIT(1'b0)) u_hold (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick),
        .pinIn   (holdRequestIn),
        .level   (holdDeb)
    );

    pss_debounce #(.RISE_TICKS(PB_RISE_TICKS), .FALL_TICKS(PB_FALL),
                   .INIT(1'b1)) u_button (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick),
        .pinIn   (powerButtonInN),
        .level   (buttonUp)
    );

    pss_debounce #(.RISE_TICKS(SLP_SYNC_TICKS), .FALL_TICKS(SLP_SYNC_TICKS),
                   .INIT(1'b1)) u_sleep (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tick    (tick),
        .pinIn   (sleepInN),
        .level   (awake)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            holdPrev   <= 1'b0;
            buttonPrev <= 1'b1;
            awakePrev  <= 1'b1;
        end else begin
            holdPrev   <= holdDeb;
            buttonPrev <= buttonUp;
            awakePrev  <= awake;
        end
    end

    logic holdRise;
    logic pressEv;
    logic sleepEv;
    assign holdRise = holdDeb & ~holdPrev;
    assign pressEv  = ~buttonUp & buttonPrev;
    assign sleepEv  = ~awake & awakePrev;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    logic       devKeep;
    logic       autoKeep;
    logic [1:0] slotSel;
    logic [2:0] sleepOffMask;    // io, core2, core1 bucks dropped in sleep
    logic       apbWrite;
    logic       lpSticky;

    assign apbWrite = psel & penable & pready & pwrite;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {sleepOffMask, slotSel, autoKeep, devKeep} <= CTRL_RESET[6:0];
        end else if (apbWrite && paddr == REG_CTRL) begin
            devKeep      <= pwdata[CTRL_DEV_KEEP];
            autoKeep     <= pwdata[CTRL_AUTO_KEEP];
            slotSel      <= pwdata[CTRL_SLOT_LO +: 2];
            sleepOffMask <= pwdata[CTRL_MASK_LO +: 3];
        end
    end

    function automatic logic [CW-1:0] stepLen(input logic [1:0] sel);
        case (sel)
            2'h1:    stepLen = CW'(STEP_TICKS_01);
            2'h2:    stepLen = CW'(STEP_TICKS_10);
            2'h3:    stepLen = CW'(STEP_TICKS_11);
            default: stepLen = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Power-on pulse and long press

    pss_state_t     state;
    logic [CW-1:0]  pulseCnt;
    logic [CW-1:0]  lpCnt;
    logic [CW-1:0]  lpOffCnt;
    logic           lpArmed;
    logic           lpKill;
    logic           keepOn;

    // Pulse only bridges the gap until software or hold takes over
    assign keepOn = (holdDeb | devKeep | autoKeep | (pulseCnt != '0)) & ~lpKill;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pulseCnt <= '0;
        end else if (state == ST_OFF && pressEv) begin
            pulseCnt <= CW'(PULSE_LEN);
        end else if (tick && pulseCnt != '0) begin
            pulseCnt <= pulseCnt - 1'b1;
        end
    end

    // Counting starts at the debounced press, so the debounce time is deducted
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lpCnt          <= '0;
            lpOffCnt       <= '0;
            lpArmed        <= 1'b0;
            lpKill         <= 1'b0;
            longPressEvent <= 1'b0;
        end else begin
            longPressEvent <= 1'b0;
            if (state == ST_OFF) begin
                lpCnt    <= '0;
                lpOffCnt <= '0;
                lpArmed  <= 1'b0;
                lpKill   <= 1'b0;
            end else if (lpArmed) begin
                if (tick) begin
                    lpOffCnt <= lpOffCnt + 1'b1;
                end
                if (lpOffCnt >= CW'(LP_OFF_LEN)) begin
                    lpKill <= 1'b1;
                end
            end else if (buttonUp) begin
                lpCnt <= '0;
            end else if (tick) begin
                lpCnt <= lpCnt + 1'b1;
                if (lpCnt + 1'b1 >= CW'(LONG_LEN - PB_FALL)) begin
                    lpArmed        <= 1'b1;
                    longPressEvent <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state machine

    logic [CW-1:0] cnt;
    logic [CW-1:0] wakeDone;
    assign wakeDone = CW'(WAKE_STEP1_AT + WAKE_BUCK_TICKS) + (stepLen(slotSel) << 1);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_OFF;
            cnt   <= '0;
        end else begin
            if (tick) begin
                cnt <= cnt + 1'b1;
            end
            case (state)
                ST_OFF: begin
                    cnt <= '0;
                    if (pressEv || holdRise) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (!keepOn) begin
                        state <= ST_STOP;
                        cnt   <= lpKill ? CW'(OFF_RST_AT) : '0;
                    end else if (cnt >= CW'(ON_RST_AT)) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE, ST_SLEEP_IN, ST_SLEEP, ST_WAKE: begin
                    if (!keepOn) begin
                        state <= ST_STOP;
                        cnt   <= lpKill ? CW'(OFF_RST_AT) : '0;
                    end else if (state == ST_ACTIVE && sleepEv) begin
                        state <= ST_SLEEP_IN;
                        cnt   <= '0;
                    end else if (state == ST_SLEEP_IN && cnt >= CW'(SLP_CLK_TICKS)) begin
                        state <= ST_SLEEP;
                    end else if (state == ST_SLEEP && awake) begin
                        state <= ST_WAKE;
                        cnt   <= '0;
                    end else if (state == ST_WAKE && cnt >= wakeDone) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_STOP: begin
                    if (cnt >= CW'(OFF_SUPPLY_AT)) begin
                        state <= ST_OFF;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    logic [7:0] next_rails;       // io, linear_reg_5, core2, core1, linear_reg_4, linear_reg_3, linear_reg_8, linear_reg_6
    logic       next_clk;
    logic       next_rst;
    logic       next_lp;
    logic [CW-1:0] len;

    always_comb begin
        len        = stepLen(slotSel);
        next_rails = '0;
        next_clk   = 1'b0;
        next_rst   = 1'b0;
        next_lp    = 1'b0;
        case (state)
            ST_START: begin
                next_rails[0] = cnt >= CW'(ON_IO_AT);
                next_rails[1] = cnt >= CW'(ON_IO_AT);
                next_rails[2] = cnt >= CW'(ON_CORE2_AT);
                next_rails[3] = cnt >= CW'(ON_CORE1_AT);
                next_rails[4] = cnt >= CW'(ON_LINEAR_REG_4_AT);
                next_rails[5] = cnt >= CW'(ON_LDO38_AT);
                next_rails[6] = cnt >= CW'(ON_LDO38_AT);
                next_rails[7] = cnt >= CW'(ON_LINEAR_REG_6_AT);
                next_clk      = cnt >= CW'(ON_CLK_AT);
                next_rst      = cnt >= CW'(ON_RST_AT);
            end
            ST_ACTIVE: begin
                next_rails = '1;
                next_clk   = 1'b1;
                next_rst   = 1'b1;
            end
            ST_SLEEP_IN, ST_SLEEP: begin
                next_rails = '1;
                next_rails[0] = ~sleepOffMask[0];
                next_rails[2] = ~sleepOffMask[1];
                next_rails[3] = ~sleepOffMask[2];
                next_lp    = 1'b1;
                next_clk   = (state == ST_SLEEP_IN) && cnt < CW'(SLP_CLK_TICKS);
                next_rst   = 1'b1;
            end
            ST_WAKE: begin
                next_rails    = '1;
                // Masked bucks take wake steps 1..3 in io, core2, core1 order
                next_rails[0] = ~sleepOffMask[0]
                    | cnt >= CW'(WAKE_STEP1_AT + WAKE_BUCK_TICKS);
                next_rails[2] = ~sleepOffMask[1]
                    | cnt >= CW'(WAKE_STEP1_AT + WAKE_BUCK_TICKS) + len;
                next_rails[3] = ~sleepOffMask[2]
                    | cnt >= CW'(WAKE_STEP1_AT + WAKE_BUCK_TICKS) + (len << 1);
                next_lp  = cnt < CW'(WAKE_HP_AT);
                next_clk = cnt >= CW'(WAKE_CLK_AT);
                next_rst = 1'b1;
            end
            ST_STOP: begin
                next_rails = {8{cnt < CW'(OFF_SUPPLY_AT)}};
                next_rst   = cnt < CW'(OFF_RST_AT);
                next_clk   = cnt < CW'(OFF_RST_AT + OFF_CLK_TICKS);
            end
            default: begin
                next_rails = '0;
            end
        endcase
    end

    logic clkRun;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {ioBuckEn, linearReg5En, core2BuckEn, core1BuckEn} <= 4'h0;
            {linearReg4En, linearReg3En, linearReg8En, linearReg6En} <= 4'h0;
            referenceEn     <= 1'b0;
            lowPowerMode    <= 1'b0;
            clkRun          <= 1'b0;
            slowClockOut    <= 1'b0;
            processorResetN <= 1'b0;
            secondResetN    <= 1'b0;
        end else begin
            {linearReg6En, linearReg8En, linearReg3En, linearReg4En} <= next_rails[7:4];
            {core1BuckEn, core2BuckEn, linearReg5En, ioBuckEn} <= next_rails[3:0];
            referenceEn     <= (state != ST_OFF) && !(state == ST_STOP
                               && cnt >= CW'(OFF_SUPPLY_AT));
            lowPowerMode    <= next_lp;
            clkRun          <= next_clk;
            slowClockOut    <= clkRun & phase;                   // held low when stopped
            processorResetN <= next_rst;
            secondResetN    <= next_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer in the second access cycle

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lpSticky <= 1'b0;
        end else if (longPressEvent) begin
            lpSticky <= 1'b1;                                    // set wins over clear
        end else if (apbWrite && paddr == REG_EVENT && pwdata[0]) begin
            lpSticky <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready
                       & !(paddr inside {REG_CTRL, REG_STATUS, REG_EVENT});
            case (paddr)
                REG_CTRL:   prdata <= {25'h0, sleepOffMask, slotSel, autoKeep, devKeep};
                REG_STATUS: prdata <= {15'h0, pulseCnt != '0, lpArmed, state,
                                       processorResetN, clkRun, lowPowerMode,
                                       referenceEn, linearReg6En, linearReg8En,
                                       linearReg3En, linearReg4En, core1BuckEn,
                                       core2BuckEn, linearReg5En, ioBuckEn};
                REG_EVENT:  prdata <= {31'h0, lpSticky};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- pss_host_model.sv ----
// Host board model: hold, power button and sleep lines
`timescale 1ns/1ps
module pss_host_model (
    input  wire logic clk_sys,
    output logic      holdRequestIn = 1'b0,
    output logic      powerButtonInN = 1'b1,
    output logic      sleepInN = 1'b1
);
    // Drive the hold, button and sleep lines together after the next clock edge
    task automatic drive(input logic h, input logic b, input logic s);
        @(posedge clk_sys);
        {holdRequestIn, powerButtonInN, sleepInN} <= {h, b, s};
    endtask
endmodule

// ---- pss_sequencer_chk.sv ----
// Checker: pin timing of the power state sequencer
`timescale 1ns/1ps
module pss_sequencer_chk #(parameter int TICK_DIV = 4) (
    input wire logic clk_sys, arst_n, ioBuckEn, core1BuckEn, core2BuckEn, linearReg3En,
    input wire logic linearReg4En, linearReg5En, linearReg6En, linearReg8En, referenceEn,
    input wire logic lowPowerMode, slowClockOut, processorResetN, secondResetN, longPressEvent
);
    localparam int LO = 2 * TICK_DIV;
    localparam int HI = 4 * TICK_DIV;
    localparam int LATE = 5 * TICK_DIV;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_rst_pair; processorResetN == secondResetN; endproperty
    a_rst_pair: assert property (p_rst_pair) else $error("reset outputs differ");
    property p_io_pair; $rose(ioBuckEn) |-> linearReg5En; endproperty
    a_io_pair: assert property (p_io_pair) else $error("io rail alone");
    property p_order; $rose(linearReg6En) |-> ioBuckEn && core2BuckEn && core1BuckEn
        && linearReg4En && linearReg3En && linearReg8En; endproperty
    a_order: assert property (p_order) else $error("rail order broken");
    property p_rst_rise; $rose(processorResetN) |-> referenceEn && linearReg6En; endproperty
    a_rst_rise: assert property (p_rst_rise) else $error("reset early");
    property p_off_sup; $fell(processorResetN) |-> ##[LO:HI] !referenceEn; endproperty
    a_off_sup: assert property (p_off_sup) else $error("supplies stay on");
    property p_off_clk; $fell(processorResetN) |-> ##LATE !slowClockOut [*8]; endproperty
    a_off_clk: assert property (p_off_clk) else $error("clock runs after off");
    property p_lp; longPressEvent |=> !longPressEvent; endproperty
    a_lp: assert property (p_lp) else $error("event too long");
    property p_slp; $rose(lowPowerMode) |-> ##LATE !slowClockOut [*8]; endproperty
    a_slp: assert property (p_slp) else $error("clock runs in sleep");
    cover property ($rose(processorResetN));
    cover property ($fell(lowPowerMode));
    cover property (longPressEvent);
endmodule
bind pss_sequencer pss_sequencer_chk #(.TICK_DIV(TICK_DIV)) pss_sequencer_chk_i (.clk_sys,
    .arst_n, .ioBuckEn, .core1BuckEn, .core2BuckEn, .linearReg3En, .linearReg4En, .linearReg5En,
    .linearReg6En, .linearReg8En, .referenceEn, .lowPowerMode, .slowClockOut, .processorResetN,
    .secondResetN, .longPressEvent);

// ---- pss_sequencer_tb_top.sv ----
// Testbench: pin and APB sequences for the power state sequencer
`timescale 1ns/1ps
module pss_sequencer_tb_top;
    import pss_pkg::*;
    logic        clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, se, ioBuckEn, core1BuckEn, core2BuckEn, linearReg3En,
                 linearReg4En, linearReg5En, linearReg6En, linearReg8En, referenceEn,
                 lowPowerMode, slowClockOut, processorResetN, secondResetN, longPressEvent,
                 holdRequestIn, powerButtonInN, sleepInN;
    int          err_total = 0, checked = 0, cyc = 0, t;
    int          lens[4] = '{0, STEP_TICKS_01, STEP_TICKS_10, STEP_TICKS_11};
    wire  [10:0] obs = {longPressEvent, lowPowerMode, referenceEn, processorResetN,
                 slowClockOut, linearReg6En, linearReg3En, linearReg4En, core1BuckEn,
                 core2BuckEn, ioBuckEn};
    always #2 clk_sys = ~clk_sys;
    pss_host_model host_i (.clk_sys, .holdRequestIn, .powerButtonInN, .sleepInN);
    pss_sequencer #(.TICK_DIV(4), .PB_FALL(3), .PULSE_LEN(200), .LONG_LEN(40), .LP_OFF_LEN(10))
        pss_sequencer_i (.clk_sys, .arst_n, .holdRequestIn, .powerButtonInN, .sleepInN, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .ioBuckEn, .core1BuckEn,
        .core2BuckEn, .linearReg3En, .linearReg4En, .linearReg5En, .linearReg6En, .linearReg8En,
        .referenceEn, .lowPowerMode, .slowClockOut, .processorResetN, .secondResetN,
        .longPressEvent);
    task automatic results;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // Drive the pins, then time the first edge at which output i shows v
    task automatic ev(input logic [2:0] p, input int i, input logic v, input int lo, input int hi);
        int s;
        host_i.drive(p[2], p[1], p[0]);
        s = cyc;
        while (obs[i] !== v) @(posedge clk_sys);
        t = cyc - s;
        chk($sformatf("delay of output %0d", i), 32'(lo), (t >= lo && t <= hi) ? 32'(lo) : 32'(t));
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        {rd, se} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", CTRL_RESET, rd);
        apb(1'b1, REG_CTRL, 32'h7F);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl rw", 32'h7F, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, se});
        apb(1'b1, REG_CTRL, 32'h0);
        $display("test regs done");
        ev(3'b111, 0, 1'b1, 268, 284);
        for (int i = 1; i < 6; i++) ev(3'b111, i, 1'b1, 252, 258);
        ev(3'b111, 6, 1'b1, 2298, 2308);
        ev(3'b111, 7, 1'b1, 250, 260);
        chk("second reset", 32'h1, {31'h0, secondResetN});
        ev(3'b011, 7, 1'b0, 5, 16);
        ev(3'b011, 8, 1'b0, 8, 16);
        $display("test switch on off done");
        apb(1'b1, REG_CTRL, 32'h1);
        ev(3'b111, 7, 1'b1, 4100, 4130);
        host_i.drive(1'b0, 1'b1, 1'b1);
        repeat (40) @(posedge clk_sys);
        chk("keep on", 32'h1, {31'h0, processorResetN});
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h2DFF, rd);
        apb(1'b1, REG_CTRL, 32'h0);
        ev(3'b011, 7, 1'b0, 4, 16);
        ev(3'b011, 8, 1'b0, 8, 16);
        $display("test keep on done");
        host_i.drive(1'b0, 1'b0, 1'b1);
        host_i.drive(1'b0, 1'b1, 1'b1);
        repeat (100) @(posedge clk_sys);
        chk("glitch", 32'h0, {31'h0, ioBuckEn});
        host_i.drive(1'b0, 1'b0, 1'b1);
        repeat (80) @(posedge clk_sys);
        ev(3'b011, 0, 1'b1, 188, 212);
        ev(3'b011, 8, 1'b0, 520, 600);
        $display("test button done");
        ev(3'b111, 7, 1'b1, 4100, 4130);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, REG_CTRL, 32'h20 | (s << 2));
            ev(3'b110, 9, 1'b1, 6, 18);
            chk("parked", 32'h0, {31'h0, core2BuckEn});
            ev(3'b111, 9, 1'b0, 28, 44);
            ev(3'b111, 1, 1'b1, 9 + 4 * lens[s], 15 + 4 * lens[s]);
            repeat (600) @(posedge clk_sys);
        end
        $display("test sleep done");
        ev(3'b101, 10, 1'b1, 154, 172);
        ev(3'b101, 7, 1'b0, 34, 48);
        apb(1'b0, REG_EVENT, 32'h0);
        chk("event", 32'h1, rd & 32'h1);
        apb(1'b1, REG_EVENT, 32'h1);
        apb(1'b0, REG_EVENT, 32'h0);
        chk("event clear", 32'h0, rd & 32'h1);
        $display("test long press done");
        results();
    end
endmodule
